// *** design/chan_compare.sv ***
// Purpose: per-division setpoint comparison for one analog group
// Assumes: unsigned samples
// Notes: HIGH selects trip above setpoint, else trip below
`timescale 1ns/10ps
`default_nettype none
module chan_compare #(
    parameter bit HIGH = 1'b0
) (
    chan_if.cmp ch // samples in, trips out
);
    genvar d;
    generate
        for (d = 0; d < 3; d++)
        begin : g_div
            assign ch.trip[d] = !ch.bypass &&
                (HIGH ? (ch.value[d] > ch.setpoint[d]) : (ch.value[d] < ch.setpoint[d]));
        end
    endgenerate
endmodule : chan_compare
`default_nettype wire

// *** design/chan_if.sv ***
// Purpose: one analog trip group: samples, setpoints, bypass and channel trips
// Assumes: three divisions per group
// Notes: carried between the top and its comparators
`timescale 1ns/10ps
`default_nettype none
interface chan_if;
    logic [2:0][15:0] value;
    logic [2:0][15:0] setpoint;
    logic bypass;
    logic [2:0] trip;
    modport cmp (input value, input setpoint, input bypass, output trip);
    modport top (output value, output setpoint, output bypass, input trip);
endinterface : chan_if
`default_nettype wire

// *** design/trip_pkg.sv ***
// Purpose: shared constants and types for the dump tank and offgas trip voting logic
// Assumes: 32-bit AHB-Lite register access, 16-bit analog samples
// Notes: offsets are byte addresses, one word per register
package trip_pkg;

    typedef logic [15:0] sample_t;
    typedef logic [2:0] mode_t;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] MODE_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CHTRIP_OFS = 8'h08;
    localparam logic [7:0] SP_BASE_OFS = 8'h10;
    localparam int NUM_SP = 18;
    localparam logic [7:0] SP_LAST_OFS = 8'h54;

    // ----------------------------------------------------------------
    // operating modes
    // ----------------------------------------------------------------
    localparam mode_t MODE_NO_SOLUTION = 3'h0;
    localparam mode_t MODE_FILL = 3'h1;
    localparam mode_t MODE_IRRADIATE = 3'h2;
    localparam mode_t MODE_POST_IRR = 3'h3;
    localparam mode_t MODE_TRANSFER = 3'h4;
    localparam mode_t MODE_RST = MODE_NO_SOLUTION;

    // ----------------------------------------------------------------
    // analog trip groups, three divisions each
    // ----------------------------------------------------------------
    localparam int NUM_DIV = 3;
    localparam int NUM_GRP = 6;
    localparam int G_OXYGEN = 0;
    localparam int G_MAINFLOW_A = 1;
    localparam int G_MAINFLOW_B = 2;
    localparam int G_SWEEP = 3;
    localparam int G_DEMISTER_A = 4;
    localparam int G_DEMISTER_B = 5;
    localparam logic [5:0] GRP_HIGH = 6'h30;
    localparam sample_t SP_LOW_RST = 16'h0000;
    localparam sample_t SP_HIGH_RST = 16'hFFFF;

    // ----------------------------------------------------------------
    // status and channel trip field positions
    // ----------------------------------------------------------------
    localparam int ST_SAFETY_BIT = 0;
    localparam int ST_PURGE_LSB = 1;
    localparam int ST_PERMIT_BIT = 4;
    localparam int ST_LOHI_VOTE_BIT = 6;
    localparam int ST_HIHI_VOTE_BIT = 7;
    localparam int ST_GRP_VOTE_LSB = 8;
    localparam int ST_MODE_LSB = 16;
    localparam int CT_LOHI_LSB = 0;
    localparam int CT_HIHI_LSB = 3;
    localparam int CT_GRP_LSB = 6;

endpackage : trip_pkg

// *** design/trip_voting_actuation_logic.sv ***
// Purpose: dump tank level and offgas trips voted into cell actuations
// Assumes: field inputs synchronous to hclk, discrete inputs active high
// Notes: registers over AHB-Lite, reads take one wait state
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - low-high level: one switch per division
// - low-high two of three trips and purges
// - low-high vote bypassed in modes three, four
// - low-high level gates transfer-to-empty mode change
// - high-high level switches voted, trip and purge
// - oxygen below setpoint trips its division
// - oxygen two of three trips and purges
// - mainstream flow per train, per division compare
// - mainstream flow vote trips and purges
// - mainstream flow bypassed without target solution
// - sweep flow, train A only, three channels
// - sweep flow vote trips and purges
// - sweep flow bypassed without target solution
// - demister temperature high, per train, division
// - demister temperature vote trips and purges
// - power loss purges divisions A, B alone
// - mode zero bypasses flows, demister, power loss
// - transfer to empty only below low-high
module trip_voting_actuation_logic
    import trip_pkg::*;
(
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic [31:0] hrdata, // read data
    output logic hresp, // always okay
    input wire logic [2:0] dump_lohi_level, // low-high switches per division
    input wire logic [2:0] dump_hihi_level, // high-high switches per division
    input wire logic [2:0][15:0] offgas_oxygen, // oxygen per division
    input wire logic [2:0][15:0] mainflow_a, // train A mainstream flow
    input wire logic [2:0][15:0] mainflow_b, // train B mainstream flow
    input wire logic [2:0][15:0] sweep_flow, // train A dump tank sweep flow
    input wire logic [2:0][15:0] demister_a, // train A demister temperature
    input wire logic [2:0][15:0] demister_b, // train B demister temperature
    input wire logic [1:0] power_loss, // safeguards line, divisions A and B
    output logic [2:0] cell_safety_trip, // per division
    output logic [2:0] cell_nitrogen_purge, // per division
    output logic xfer_exit_permit // level below low-high
);

    // ----------------------------------------------------------------
    // trip groups and votes
    // ----------------------------------------------------------------
    mode_t op_mode;
    mode_t next_op_mode;
    sample_t sp [NUM_SP];
    sample_t next_sp [NUM_SP];
    logic [NUM_GRP-1:0][2:0][15:0] grp_value;
    logic [NUM_GRP-1:0] grp_bypass;
    logic [NUM_GRP-1:0][2:0] grp_trip;
    logic [NUM_GRP-1:0] grp_vote;
    logic [2:0] lohi_masked;
    logic lohi_vote;
    logic lohi_raw_vote;
    logic hihi_vote;
    logic no_solution;

    assign grp_value = {demister_b, demister_a, sweep_flow, mainflow_b, mainflow_a,
                        offgas_oxygen};
    assign no_solution = (op_mode == MODE_NO_SOLUTION);

    always_comb
    begin
        grp_bypass = '0;
        grp_bypass[G_MAINFLOW_A] = no_solution;
        grp_bypass[G_MAINFLOW_B] = no_solution;
        grp_bypass[G_SWEEP] = no_solution;
        grp_bypass[G_DEMISTER_A] = no_solution;
        grp_bypass[G_DEMISTER_B] = no_solution;
    end

    chan_if chans [NUM_GRP] ();

    genvar g, d;
    generate
        for (g = 0; g < NUM_GRP; g++)
        begin : g_grp
            assign chans[g].value = grp_value[g];
            assign chans[g].bypass = grp_bypass[g];
            assign grp_trip[g] = chans[g].trip;
            for (d = 0; d < NUM_DIV; d++)
            begin : g_sp
                // one setpoint per division and group
                assign chans[g].setpoint[d] = sp[g * NUM_DIV + d];
            end
            chan_compare #(
                .HIGH(GRP_HIGH[g])
            ) u_cmp (
                .ch(chans[g])
            );
            vote_2oo3 u_vote (
                .trip(grp_trip[g]),
                .vote(grp_vote[g])
            );
        end
    endgenerate

    // low-high masked in modes three, four
    assign lohi_masked = (op_mode == MODE_POST_IRR || op_mode == MODE_TRANSFER) ?
                         3'h0 : dump_lohi_level;

    vote_2oo3 u_lohi (
        .trip(lohi_masked),
        .vote(lohi_vote)
    );

    vote_2oo3 u_lohi_raw (
        .trip(dump_lohi_level),
        .vote(lohi_raw_vote)
    );

    vote_2oo3 u_hihi (
        .trip(dump_hihi_level),
        .vote(hihi_vote)
    );

    // ----------------------------------------------------------------
    // actuation outputs
    // ----------------------------------------------------------------
    logic [2:0] next_safety;
    logic [2:0] next_purge;
    logic next_permit;
    logic any_vote;

    always_comb
    begin
        any_vote = lohi_vote | hihi_vote | (|grp_vote);
        next_safety = {3{any_vote}};
        next_purge = {3{any_vote}};
        next_purge[0] = any_vote | (power_loss[0] & ~no_solution);
        next_purge[1] = any_vote | (power_loss[1] & ~no_solution);
        // level above low-high on two switches blocks leaving transfer
        next_permit = ~lohi_raw_vote;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cell_safety_trip <= 3'h0;
            cell_nitrogen_purge <= 3'h0;
            xfer_exit_permit <= 1'b0;
        end
        else
        begin
            cell_safety_trip <= next_safety;
            cell_nitrogen_purge <= next_purge;
            xfer_exit_permit <= next_permit;
        end
    end

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    logic [7:0] addr_q;
    logic [7:0] next_addr_q;
    logic wr_pend;
    logic next_wr_pend;
    logic rd_pend;
    logic next_rd_pend;
    logic next_hreadyout;
    logic [31:0] next_hrdata;
    logic take;
    logic [31:0] rd_word;
    logic [31:0] status_word;
    logic [31:0] chtrip_word;
    logic [7:0] sp_idx;

    assign take = hsel && htrans[1] && hready;
    assign sp_idx = 8'((addr_q - SP_BASE_OFS) >> 2);

    always_comb
    begin
        status_word = '0;
        status_word[ST_SAFETY_BIT] = cell_safety_trip[0];
        status_word[ST_PURGE_LSB +: 3] = cell_nitrogen_purge;
        status_word[ST_PERMIT_BIT] = xfer_exit_permit;
        status_word[ST_LOHI_VOTE_BIT] = lohi_vote;
        status_word[ST_HIHI_VOTE_BIT] = hihi_vote;
        status_word[ST_GRP_VOTE_LSB +: NUM_GRP] = grp_vote;
        status_word[ST_MODE_LSB +: 3] = op_mode;
        chtrip_word = '0;
        chtrip_word[CT_LOHI_LSB +: 3] = lohi_masked;
        chtrip_word[CT_HIHI_LSB +: 3] = dump_hihi_level;
        chtrip_word[CT_GRP_LSB +: NUM_GRP * 3] = grp_trip;
        rd_word = '0;
        if (addr_q == MODE_OFS)
            rd_word[2:0] = op_mode;
        else if (addr_q == STATUS_OFS)
            rd_word = status_word;
        else if (addr_q == CHTRIP_OFS)
            rd_word = chtrip_word;
        else if (addr_q >= SP_BASE_OFS && addr_q <= SP_LAST_OFS && addr_q[1:0] == 2'h0)
            rd_word[15:0] = sp[sp_idx[4:0]];
    end

    // reads wait one cycle so a write just before is already visible
    always_comb
    begin
        next_addr_q = addr_q;
        next_wr_pend = 1'b0;
        next_rd_pend = 1'b0;
        next_hreadyout = 1'b1;
        next_hrdata = hrdata;
        if (rd_pend)
            next_hrdata = rd_word;
        if (take)
        begin
            next_addr_q = haddr[7:0];
            next_wr_pend = hwrite;
            next_rd_pend = ~hwrite;
            next_hreadyout = hwrite;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_q <= 8'h00;
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
        end
        else
        begin
            addr_q <= next_addr_q;
            wr_pend <= next_wr_pend;
            rd_pend <= next_rd_pend;
            hreadyout <= next_hreadyout;
            hrdata <= next_hrdata;
            hresp <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // mode and setpoint registers
    // ----------------------------------------------------------------
    logic mode_ok;

    always_comb
    begin
        // transfer to empty only when permitted
        mode_ok = (hwdata[31:3] == '0) && (hwdata[2:0] <= MODE_TRANSFER) &&
                  !(op_mode == MODE_TRANSFER && hwdata[2:0] == MODE_NO_SOLUTION &&
                    !xfer_exit_permit);
        next_op_mode = op_mode;
        next_sp = sp;
        if (wr_pend)
        begin
            if (addr_q == MODE_OFS && mode_ok)
                next_op_mode = hwdata[2:0];
            else if (addr_q >= SP_BASE_OFS && addr_q <= SP_LAST_OFS && addr_q[1:0] == 2'h0)
                next_sp[sp_idx[4:0]] = hwdata[15:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            op_mode <= MODE_RST;
            for (int i = 0; i < NUM_SP; i++)
                sp[i] <= (i >= G_DEMISTER_A * NUM_DIV) ? SP_HIGH_RST : SP_LOW_RST;
        end
        else
        begin
            op_mode <= next_op_mode;
            sp <= next_sp;
        end
    end

endmodule : trip_voting_actuation_logic
`default_nettype wire

// *** design/vote_2oo3.sv ***
// Purpose: two-out-of-three vote
// Assumes: inputs already masked by bypass
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
module vote_2oo3 (
    input wire logic [2:0] trip, // channel trips
    output logic vote // two or more active
);
    assign vote = (trip[0] & trip[1]) | (trip[0] & trip[2]) | (trip[1] & trip[2]);
endmodule : vote_2oo3
`default_nettype wire

// *** sim/field_model.sv ***
// Purpose: field sensors and safeguards loss-of-power line
// Assumes: the bench sets the sample and switch variables
// Notes: the loss delay is shortened to a few cycles
`timescale 1ns/10ps
`default_nettype none
module field_model #(
    parameter int LOSS_DELAY = 8
) (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, low
    output logic [2:0] dump_lohi_level, // low-high
    output logic [2:0] dump_hihi_level, // high-high
    output logic [2:0][15:0] offgas_oxygen, // oxygen
    output logic [2:0][15:0] mainflow_a, // flow A
    output logic [2:0][15:0] mainflow_b, // flow B
    output logic [2:0][15:0] sweep_flow, // sweep
    output logic [2:0][15:0] demister_a, // temp A
    output logic [2:0][15:0] demister_b, // temp B
    output logic [1:0] power_loss // loss lines
);
    logic [5:0][2:0][15:0] grp;
    logic [2:0] lohi;
    logic [2:0] hihi;
    logic ext_lost;
    logic [1:0] loss_mask;
    int loss_cnt;
    initial
    begin
        grp = '0;
        lohi = 3'h0;
        hihi = 3'h0;
        ext_lost = 1'b0;
        loss_mask = 2'h0;
    end
    assign dump_lohi_level = lohi;
    assign dump_hihi_level = hihi;
    assign offgas_oxygen = grp[0];
    assign mainflow_a = grp[1];
    assign mainflow_b = grp[2];
    assign sweep_flow = grp[3];
    assign demister_a = grp[4];
    assign demister_b = grp[5];
    // line held back until the delay runs out
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn || !ext_lost)
            loss_cnt <= 0;
        else if (loss_cnt < LOSS_DELAY)
            loss_cnt <= loss_cnt + 1;
    end
    // one indication drives each line set in loss_mask
    assign power_loss = (loss_cnt >= LOSS_DELAY) ? loss_mask : 2'h0;
endmodule : field_model
`default_nettype wire

// *** sim/trip_voting_actuation_logic_bench.sv ***
// Purpose: self-checking bench of the trip voting block
// Assumes: bench is the only bus master
// Notes: setpoints differ per group and division
`timescale 1ns/10ps
`default_nettype none
module trip_voting_actuation_logic_bench
    import trip_pkg::*;
;
    localparam int DLY = 4;
    typedef struct packed {
        mode_t mode;
        logic [3:0] src;
        logic [2:0] act;
        logic [2:0] safe;
        logic [2:0] purge;
    } row_s;
    // ----------------------------------------------------------------
    // source 0..5 analog group, 6 low-high, 7 high-high, 8 loss
    // ----------------------------------------------------------------
    localparam row_s ROWS [18] = '{
        '{3'h2, 4'h0, 3'h3, 3'h7, 3'h7}, '{3'h2, 4'h0, 3'h4, 3'h0, 3'h0},
        '{3'h2, 4'h1, 3'h5, 3'h7, 3'h7}, '{3'h2, 4'h2, 3'h6, 3'h7, 3'h7},
        '{3'h2, 4'h3, 3'h3, 3'h7, 3'h7}, '{3'h2, 4'h4, 3'h7, 3'h7, 3'h7},
        '{3'h1, 4'h5, 3'h3, 3'h7, 3'h7}, '{3'h0, 4'h1, 3'h7, 3'h0, 3'h0},
        '{3'h0, 4'h3, 3'h7, 3'h0, 3'h0}, '{3'h0, 4'h5, 3'h7, 3'h0, 3'h0},
        '{3'h0, 4'h0, 3'h3, 3'h7, 3'h7}, '{3'h2, 4'h6, 3'h3, 3'h7, 3'h7},
        '{3'h3, 4'h6, 3'h7, 3'h0, 3'h0}, '{3'h4, 4'h6, 3'h6, 3'h0, 3'h0},
        '{3'h3, 4'h7, 3'h5, 3'h7, 3'h7}, '{3'h2, 4'h8, 3'h1, 3'h0, 3'h1},
        '{3'h1, 4'h8, 3'h2, 3'h0, 3'h2}, '{3'h0, 4'h8, 3'h3, 3'h0, 3'h0}};
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, xfer_exit_permit;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, power_loss;
    logic [2:0] hsize, dump_lohi_level, dump_hihi_level, cell_safety_trip, cell_nitrogen_purge;
    logic [2:0][15:0] offgas_oxygen, mainflow_a, mainflow_b, sweep_flow, demister_a, demister_b;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    trip_voting_actuation_logic DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .dump_lohi_level,
        .dump_hihi_level, .offgas_oxygen, .mainflow_a, .mainflow_b, .sweep_flow, .demister_a,
        .demister_b, .power_loss, .cell_safety_trip, .cell_nitrogen_purge, .xfer_exit_permit);
    field_model #(.LOSS_DELAY(DLY)) fm (.hclk, .hresetn, .dump_lohi_level, .dump_hihi_level,
        .offgas_oxygen, .mainflow_a, .mainflow_b, .sweep_flow, .demister_a, .demister_b,
        .power_loss);
    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // a hung handshake ends here
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    function automatic logic [15:0] spv(input int g, input int d);
        return 16'(4096 + g * 256 + d * 16);
    endfunction : spv
    // strict compare: equal to the setpoint never trips
    task automatic drive(input logic [3:0] src, input logic [2:0] act);
        for (int g = 0; g < NUM_GRP; g++)
            for (int d = 0; d < NUM_DIV; d++)
                fm.grp[g][d] <= spv(g, d) + ((src == 4'(g) && act[d])
                    ? (GRP_HIGH[g] ? 16'h0001 : 16'hFFFF) : 16'h0000);
        fm.lohi <= (src == 4'h6) ? act : 3'h0;
        fm.hihi <= (src == 4'h7) ? act : 3'h0;
        fm.loss_mask <= act[1:0];
        fm.ext_lost <= (src == 4'h8);
    endtask : drive
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (10) @(posedge hclk);
        chk("purge in reset", 32'h0, 32'(cell_nitrogen_purge));
        chk("permit in reset", 32'h0, 32'(xfer_exit_permit));
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, MODE_OFS, 32'h0);
        chk("mode reset", 32'h0, rd);
        bus(1'b0, SP_BASE_OFS + 8'h30, 32'h0);
        chk("demister setpoint reset", 32'(SP_HIGH_RST), rd);
        for (int i = 0; i < NUM_SP; i++)
            bus(1'b1, SP_BASE_OFS + 8'(4 * i), {16'h0, spv(i / 3, i % 3)});
        bus(1'b0, SP_LAST_OFS, 32'h0);
        chk("last setpoint", {16'h0, spv(5, 2)}, rd);
        drive(4'hF, 3'h0);
        $display("test reset and setpoints done");
        foreach (ROWS[i])
        begin
            bus(1'b1, MODE_OFS, 32'(ROWS[i].mode));
            drive(ROWS[i].src, ROWS[i].act);
            repeat (DLY + 3) @(posedge hclk);
            chk("safety", 32'(ROWS[i].safe), 32'(cell_safety_trip));
            chk("purge", 32'(ROWS[i].purge), 32'(cell_nitrogen_purge));
            drive(4'hF, 3'h0);
            repeat (3) @(posedge hclk);
            $display("test row %0d done", i);
        end
        bus(1'b1, MODE_OFS, 32'h2);
        bus(1'b1, MODE_OFS, 32'h5);
        bus(1'b1, MODE_OFS, 32'h103);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("status mode", 32'h2, 32'(rd[18:16]));
        bus(1'b1, 8'h0C, 32'hFFFFFFFF);
        bus(1'b0, 8'h0C, 32'h0);
        chk("unmapped read", 32'h0, rd);
        $display("test refusals done");
        bus(1'b1, MODE_OFS, 32'h4);
        drive(4'h6, 3'h3);
        repeat (3) @(posedge hclk);
        chk("permit with level", 32'h0, 32'(xfer_exit_permit));
        chk("bypassed level", 32'h0, 32'(cell_safety_trip));
        bus(1'b1, MODE_OFS, 32'h0);
        bus(1'b0, MODE_OFS, 32'h0);
        chk("mode held", 32'h4, rd);
        drive(4'hF, 3'h0);
        repeat (3) @(posedge hclk);
        bus(1'b1, MODE_OFS, 32'h0);
        bus(1'b0, MODE_OFS, 32'h0);
        chk("mode to empty", 32'h0, rd);
        $display("test permissive done");
        drive(4'h7, 3'h7);
        repeat (3) @(posedge hclk);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("status word", 32'h0000009F, rd);
        bus(1'b0, CHTRIP_OFS, 32'h0);
        chk("channel trips", 32'h00000038, rd);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("safety in reset", 32'h0, 32'(cell_safety_trip));
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("safety after reset", 32'h7, 32'(cell_safety_trip));
        $display("test mid-run reset done");
        tally_and_finish();
    end
endmodule : trip_voting_actuation_logic_bench
bind trip_voting_actuation_logic trip_voting_actuation_logic_props props_i (.hclk, .hresetn,
    .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .dump_lohi_level, .dump_hihi_level,
    .power_loss, .cell_safety_trip, .cell_nitrogen_purge, .xfer_exit_permit);
`default_nettype wire

// *** sim/trip_voting_actuation_logic_props.sv ***
// Purpose: port checks of the trip voting block
// Assumes: one clock, async active-low reset
// Notes: mode is internal, so unbypassed sources are used
`timescale 1ns/10ps
`default_nettype none
module trip_voting_actuation_logic_props (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, low
    input wire logic hsel, // select
    input wire logic [1:0] htrans, // transfer
    input wire logic hwrite, // write
    input wire logic hready, // bus ready
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic [2:0] dump_lohi_level, // low-high
    input wire logic [2:0] dump_hihi_level, // high-high
    input wire logic [1:0] power_loss, // loss lines
    input wire logic [2:0] cell_safety_trip, // trips
    input wire logic [2:0] cell_nitrogen_purge, // purges
    input wire logic xfer_exit_permit // permit
);
    default clocking @(posedge hclk); endclocking
    // the edge that lifts reset still sees outputs held in reset
    logic out_of_reset;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            out_of_reset <= 1'b0;
        else
            out_of_reset <= 1'b1;
    end
    default disable iff (!hresetn || !out_of_reset);
    logic take;
    assign take = hsel && htrans[1] && hready;
    hihi_vote_a: assert property (
        $countones(dump_hihi_level) >= 2 |=> cell_safety_trip == 3'h7
        && cell_nitrogen_purge == 3'h7) else $error("high-high vote missed");
    trip_unison_a: assert property (
        cell_safety_trip == 3'h0 || cell_safety_trip == 3'h7) else $error("divisions split");
    trip_brings_purge_a: assert property (
        cell_safety_trip[0] |-> cell_nitrogen_purge == 3'h7) else $error("trip without purge");
    purge_c_vote_a: assert property (
        cell_nitrogen_purge[2] == cell_safety_trip[2]) else $error("division C purge alone");
    purge_a_cause_a: assert property (
        cell_nitrogen_purge[0] && !cell_safety_trip[0] |-> $past(power_loss[0]))
        else $error("division A purge without loss");
    purge_b_cause_a: assert property (
        cell_nitrogen_purge[1] && !cell_safety_trip[1] |-> $past(power_loss[1]))
        else $error("division B purge without loss");
    permit_drop_a: assert property (
        $countones(dump_lohi_level) >= 2 |=> !xfer_exit_permit) else $error("permit kept");
    permit_give_a: assert property (
        $countones(dump_lohi_level) < 2 |=> xfer_exit_permit) else $error("permit withheld");
    read_wait_a: assert property (
        take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    write_nowait_a: assert property (
        take && hwrite |=> hreadyout) else $error("write stalled");
    resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
endmodule : trip_voting_actuation_logic_props
`default_nettype wire
